// ==== rtl/pfd_pkg.sv ====
package pfd_pkg;

	// ****************************************************************
	// clock and link timing
	// ****************************************************************
	localparam int PFD_CLK_PERIOD_NS = 50;
	localparam int PFD_NS_PER_US = 1000;
	// carrier_gap_time: fixed carrier dropout before every channel
	localparam int PFD_GAP_TIME_US = 500;
	// on-interval of each fixed-width digital-code channel
	localparam int PFD_FIX_SPAN_US = 500;
	// shortest frame_marker_length that the receiver accepts
	localparam int PFD_MARKER_MIN_US = 5000;
	// receiver sync timeout; every channel on-interval must stay below it
	localparam int PFD_TIMEOUT_US = 3500;
	// longest analog on-interval we ever send
	localparam int PFD_SPAN_MAX_US = 3000;

	// exact figures, least times rounded up, longest times rounded down
	localparam int PFD_GAP_CYC = PFD_GAP_TIME_US * PFD_NS_PER_US / PFD_CLK_PERIOD_NS;
	localparam int PFD_FIX_CYC = PFD_FIX_SPAN_US * PFD_NS_PER_US / PFD_CLK_PERIOD_NS;
	localparam int PFD_MARKER_CYC = (PFD_MARKER_MIN_US * PFD_NS_PER_US + PFD_CLK_PERIOD_NS - 1)
		/ PFD_CLK_PERIOD_NS;
	localparam int PFD_TIMEOUT_CYC = PFD_TIMEOUT_US * PFD_NS_PER_US / PFD_CLK_PERIOD_NS;
	localparam int PFD_SPAN_MAX_CYC = PFD_SPAN_MAX_US * PFD_NS_PER_US / PFD_CLK_PERIOD_NS;

	// ****************************************************************
	// frame layout
	// ****************************************************************
	localparam int PFD_CNT_W = 17;
	localparam int PFD_SLOT_W = 3;
	localparam int PFD_CODE_W = 2;
	// two analog channels plus at least one digital-code channel
	localparam logic [PFD_SLOT_W-1:0] PFD_BASE_CHANNELS = 3'h3;
	localparam logic [PFD_SLOT_W-1:0] PFD_SLOT_CH1 = 3'h0;
	localparam logic [PFD_SLOT_W-1:0] PFD_SLOT_CH2 = 3'h1;
	localparam logic [PFD_SLOT_W-1:0] PFD_SLOT_STEP = 3'h1;
	localparam logic [PFD_SLOT_W-1:0] PFD_MAX_CHANNELS = 3'h6;

	typedef enum logic [1:0] {
		PFD_ST_START,
		PFD_ST_SYNC,
		PFD_ST_GAP,
		PFD_ST_ON
	} pfd_state_t;

endpackage

// ==== rtl/pfd_interval_timer.sv ====
`timescale 1ns/1ps

// ****************************************************************
// down counter that times one carrier interval
// ****************************************************************
module pfd_interval_timer
	import pfd_pkg::*;
#(
	parameter int CNT_W = PFD_CNT_W
) (
	input wire logic core_clk_i,             // system clock
	input wire logic reset_n_i,              // async reset, active low
	input wire logic start_i,                // load a new interval
	input wire logic [CNT_W-1:0] length_i,   // interval length in cycles, at least 1
	output logic last_o                      // final cycle of the interval
);

	typedef struct packed {
		logic [CNT_W-1:0] remaining;
	} pfd_tmr_st_t;

	pfd_tmr_st_t st_q;
	pfd_tmr_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (start_i) begin
			st_d.remaining = length_i - CNT_W'(1);
		end else if (st_q.remaining != '0) begin
			st_d.remaining = st_q.remaining - CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign last_o = (st_q.remaining == '0);

	chk_timer_load: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		start_i && length_i > CNT_W'(1) |=> !last_o)
		else $error("interval ended right after a load");

endmodule

// ==== rtl/pfd_frame_encoder.sv ====
`timescale 1ns/1ps

module pfd_frame_encoder
	import pfd_pkg::*;
#(
	parameter int CNT_W = PFD_CNT_W,
	parameter int GAP_CYC = PFD_GAP_CYC,
	parameter int FIX_CYC = PFD_FIX_CYC,
	parameter int MARKER_CYC = PFD_MARKER_CYC,
	parameter int TIMEOUT_CYC = PFD_TIMEOUT_CYC,
	parameter int SPAN_MAX_CYC = PFD_SPAN_MAX_CYC
) (
	input wire logic core_clk_i,               // system clock, 20 MHz
	input wire logic reset_n_i,                // async reset, active low
	input wire logic [CNT_W-1:0] ch1_span_i,   // analog channel 1 carrier-on cycles
	input wire logic [CNT_W-1:0] ch2_span_i,   // analog channel 2 carrier-on cycles
	input wire logic dig_a_i,                  // digital channel A level
	input wire logic dig_b_i,                  // digital channel B level
	output logic carrier_on_o,                 // transmit carrier, high = on
	output logic frame_start_o                 // one-cycle pulse at first gap of a frame
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (MARKER_CYC >= (1 << CNT_W) || GAP_CYC < 1 || FIX_CYC < 1 || SPAN_MAX_CYC < 1) begin : g_bad_width
		$error("interval counts do not fit the timer");
	end
	if (SPAN_MAX_CYC >= TIMEOUT_CYC || FIX_CYC >= TIMEOUT_CYC || MARKER_CYC <= TIMEOUT_CYC) begin : g_bad_timing
		$error("channel and marker lengths must straddle the receiver timeout");
	end

	localparam logic [CNT_W-1:0] GAP_LEN = CNT_W'(GAP_CYC);
	localparam logic [CNT_W-1:0] FIX_LEN = CNT_W'(FIX_CYC);
	localparam logic [CNT_W-1:0] MARKER_LEN = CNT_W'(MARKER_CYC);
	localparam logic [CNT_W-1:0] SPAN_MAX_LEN = CNT_W'(SPAN_MAX_CYC);
	localparam logic [CNT_W-1:0] SPAN_MIN_LEN = CNT_W'(1);

	typedef struct packed {
		pfd_state_t state;
		logic [PFD_SLOT_W-1:0] slot;
		logic [PFD_CODE_W-1:0] code;
		logic [CNT_W-1:0] ch1;
		logic [CNT_W-1:0] ch2;
		logic carrier;
		logic frame_start;
		logic [CNT_W-1:0] on_run;
		logic [CNT_W-1:0] off_run;
	} pfd_enc_st_t;

	pfd_enc_st_t st_q;
	pfd_enc_st_t st_d;
	logic tmr_start;
	logic [CNT_W-1:0] tmr_len;
	logic tmr_last;
	logic [PFD_SLOT_W-1:0] total_ch;

	function automatic logic [CNT_W-1:0] pfd_clamp(input logic [CNT_W-1:0] span);
		if (span < SPAN_MIN_LEN) begin
			return SPAN_MIN_LEN;
		end else if (span > SPAN_MAX_LEN) begin
			return SPAN_MAX_LEN;
		end
		return span;
	endfunction

	// ****************************************************************
	// frame sequencer
	// ****************************************************************
	// digital code d sends d+1 extra channels, so the frame has d+3
	assign total_ch = PFD_SLOT_W'(st_q.code) + PFD_BASE_CHANNELS;

	always_comb begin
		st_d = st_q;
		st_d.frame_start = 1'b0;
		// carrier run lengths, watched by the checks below
		st_d.on_run = st_q.carrier ? st_q.on_run + CNT_W'(1) : '0;
		st_d.off_run = st_q.carrier ? '0 : st_q.off_run + CNT_W'(1);
		tmr_start = 1'b0;
		tmr_len = GAP_LEN;
		unique case (st_q.state)
			PFD_ST_START: begin
				// open with a full marker so the receiver starts clean
				st_d.state = PFD_ST_SYNC;
				st_d.carrier = 1'b1;
				tmr_start = 1'b1;
				tmr_len = MARKER_LEN;
			end
			PFD_ST_SYNC: begin
				if (tmr_last) begin
					st_d.state = PFD_ST_GAP;
					st_d.carrier = 1'b0;
					st_d.slot = PFD_SLOT_CH1;
					st_d.code = {dig_b_i, dig_a_i};
					st_d.ch1 = pfd_clamp(ch1_span_i);
					st_d.ch2 = pfd_clamp(ch2_span_i);
					st_d.frame_start = 1'b1;
					tmr_start = 1'b1;
					tmr_len = GAP_LEN;
				end
			end
			PFD_ST_GAP: begin
				if (tmr_last) begin
					tmr_start = 1'b1;
					st_d.carrier = 1'b1;
					if (st_q.slot == total_ch) begin
						// marker closes the frame after the last channel
						st_d.state = PFD_ST_SYNC;
						tmr_len = MARKER_LEN;
					end else begin
						st_d.state = PFD_ST_ON;
						if (st_q.slot == PFD_SLOT_CH1) begin
							tmr_len = st_q.ch1;
						end else if (st_q.slot == PFD_SLOT_CH2) begin
							tmr_len = st_q.ch2;
						end else begin
							tmr_len = FIX_LEN;
						end
					end
				end
			end
			PFD_ST_ON: begin
				if (tmr_last) begin
					st_d.state = PFD_ST_GAP;
					st_d.carrier = 1'b0;
					st_d.slot = st_q.slot + PFD_SLOT_STEP;
					tmr_start = 1'b1;
					tmr_len = GAP_LEN;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '{state: PFD_ST_START, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	pfd_interval_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.start_i(tmr_start),
		.length_i(tmr_len),
		.last_o(tmr_last)
	);

	assign carrier_on_o = st_q.carrier;
	assign frame_start_o = st_q.frame_start;

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_gap_length: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(carrier_on_o) && $past(st_q.state) == PFD_ST_GAP |-> st_q.off_run == GAP_LEN)
		else $error("carrier gap not of fixed length");

	chk_analog_span: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(carrier_on_o) && $past(st_q.state) == PFD_ST_ON && st_q.slot == PFD_SLOT_CH2
		|-> st_q.on_run == st_q.ch1)
		else $error("channel 1 on-interval differs from its span");

	chk_ch2_span: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(carrier_on_o) && $past(st_q.state) == PFD_ST_ON && st_q.slot == PFD_SLOT_CH2 + PFD_SLOT_STEP
		|-> st_q.on_run == st_q.ch2)
		else $error("channel 2 on-interval differs from its span");

	chk_marker_long: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(carrier_on_o) && $past(st_q.state) == PFD_ST_SYNC |-> st_q.on_run >= MARKER_LEN)
		else $error("frame marker too short");

	chk_span_short: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(carrier_on_o) && $past(st_q.state) == PFD_ST_ON |-> st_q.on_run <= SPAN_MAX_LEN)
		else $error("channel on-interval reaches the receiver timeout");

	chk_digital_width: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(carrier_on_o) && $past(st_q.state) == PFD_ST_ON && st_q.slot > PFD_SLOT_CH2 + PFD_SLOT_STEP
		|-> st_q.on_run == FIX_LEN)
		else $error("digital-code channel not of fixed width");

	chk_start_gap: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		frame_start_o |-> !carrier_on_o && $past(carrier_on_o))
		else $error("frame start not at the end of a marker");

	chk_first_slot: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		frame_start_o |-> st_q.state == PFD_ST_GAP && st_q.slot == PFD_SLOT_CH1)
		else $error("frame does not open with the channel 1 gap");

	chk_code_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		st_q.state != PFD_ST_SYNC |=> $stable(st_q.code))
		else $error("digital code changed inside a frame");

	chk_channel_count: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		st_q.state == PFD_ST_GAP ##1 st_q.state == PFD_ST_SYNC
		|-> st_q.slot >= PFD_BASE_CHANNELS && st_q.slot <= PFD_MAX_CHANNELS && st_q.slot == total_ch)
		else $error("frame channel count does not match the digital code");

	chk_marker_last: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		st_q.state == PFD_ST_ON |-> st_q.slot < total_ch)
		else $error("channel sent after the frame should have closed");

endmodule

// ==== dv/pfd_rx_model.sv ====
`timescale 1ns/1ps

// ****************************************************************
// receiver model: counts carrier drops, decodes slots, latches code
// ****************************************************************
module pfd_rx_model
	import pfd_pkg::*;
#(
	// defaults sized for the short bench timing
	parameter int TIMEOUT_CYC = 50,
	parameter int OS_CYC = 2,
	parameter int DLY_CYC = 3
) (
	input wire logic core_clk_i, // system clock
	input wire logic reset_n_i,  // async reset, active low
	input wire logic carrier_i,  // received carrier, high = on
	output logic ch1_o,          // analog channel 1 pulse
	output logic ch2_o,          // analog channel 2 pulse
	output logic dig_a_o,        // digital output A
	output logic dig_b_o,        // digital output B
	output logic latch_o         // one cycle at the midpoint of the read one-shot, after the outputs load
);
	// loss is seen only once the whole line has emptied
	logic [DLY_CYC-1:0] seen_q;
	logic det_q;
	logic [PFD_SLOT_W-1:0] cnt_q;
	int tmr_q;
	int os_q;
	wire det = |seen_q;
	assign ch1_o = cnt_q == 3'h1;
	assign ch2_o = cnt_q == 3'h2;
	assign latch_o = os_q == OS_CYC;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seen_q <= '0;
			det_q <= 1'b0;
			cnt_q <= '0;
			tmr_q <= 0;
			os_q <= 0;
			dig_a_o <= 1'b0;
			dig_b_o <= 1'b0;
		end else begin
			seen_q <= {seen_q[DLY_CYC-2:0], carrier_i};
			det_q <= det;
			if (det_q && !det) cnt_q <= cnt_q + 3'h1;
			if (!det) tmr_q <= 0;
			else if (tmr_q < TIMEOUT_CYC) tmr_q <= tmr_q + 1;
			if (det && tmr_q == TIMEOUT_CYC - 1) os_q <= 1;
			else if (os_q == 2 * OS_CYC) os_q <= 0;
			else if (os_q > 0) os_q <= os_q + 1;
			if (os_q > 0 && os_q < OS_CYC) begin
				dig_a_o <= cnt_q[0];
				dig_b_o <= cnt_q[1];
			end
			if (os_q == 2 * OS_CYC) cnt_q <= '0;
		end
	end
endmodule

// ==== dv/tb_pfd_frame_encoder.sv ====
`timescale 1ns/1ps

// ****************************************************************
// frame encoder bench against the receiver model
// ****************************************************************
module tb_pfd_frame_encoder;
	import pfd_pkg::*;
	localparam int GAP = 10;
	localparam int SMAX = 40;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [PFD_CNT_W-1:0] ch1_span;
	logic [PFD_CNT_W-1:0] ch2_span;
	logic dig_a, dig_b, carrier_on, frame_start, ch1, ch2, dig_a_rx, dig_b_rx, latch;
	int err_count = 0;
	int n_compared = 0;
	int w1 = 0;
	int w2 = 0;
	logic prev_car = 1'b0;
	integer seed = 32'h7595;
	int q1[$];
	int q2[$];
	logic [1:0] qc[$];

	always #25 core_clk_i = ~core_clk_i;

	pfd_frame_encoder #(.GAP_CYC(GAP), .FIX_CYC(10), .MARKER_CYC(60), .TIMEOUT_CYC(50),
		.SPAN_MAX_CYC(SMAX)) dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.ch1_span_i(ch1_span), .ch2_span_i(ch2_span), .dig_a_i(dig_a), .dig_b_i(dig_b),
		.carrier_on_o(carrier_on), .frame_start_o(frame_start));

	pfd_rx_model rx (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .carrier_i(carrier_on), .ch1_o(ch1), .ch2_o(ch2),
		.dig_a_o(dig_a_rx), .dig_b_o(dig_b_rx), .latch_o(latch));

	task automatic end_sim();
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cmp_width(input int got, ref int q[$]);
		n_compared++;
		if (q.size() == 0 || q[0] != got) begin
			err_count++;
			$display("[FAIL] %0t: pulse width %0d unexpected", $time, got);
		end
		if (q.size() > 0) void'(q.pop_front());
	endtask

	task automatic cmp_code(input logic [1:0] got, ref logic [1:0] q[$]);
		n_compared++;
		if (q.size() == 0 || q[0] !== got) begin
			err_count++;
			$display("[FAIL] %0t: latched code %b unexpected", $time, got);
		end
		if (q.size() > 0) void'(q.pop_front());
	endtask

	// frame start must fall in the first cycle after the carrier drop
	task automatic cmp_start(input logic [1:0] got);
		n_compared++;
		if (got !== 2'b10) begin
			err_count++;
			$display("[FAIL] %0t: frame start not at carrier drop", $time);
		end
	endtask

	// out-of-range spans are clamped by the encoder
	function automatic int clamp(input int s);
		return s == 0 ? 1 : (s > SMAX ? SMAX : s);
	endfunction

	task automatic set_frame(input int i);
		int s1, s2;
		s1 = $unsigned($random(seed)) % (SMAX + 6);
		s2 = $unsigned($random(seed)) % (SMAX + 6);
		if (i == 5) s1 = 0;
		ch1_span = PFD_CNT_W'(s1);
		ch2_span = PFD_CNT_W'(s2);
		dig_a = i[0];
		dig_b = i[1];
		q1.push_back(GAP + clamp(s1));
		q2.push_back(GAP + clamp(s2));
		qc.push_back(2'(i));
	endtask

	task automatic wait_start();
		int k;
		@(negedge core_clk_i);
		for (k = 0; k < 2000 && frame_start !== 1'b1; k++) @(negedge core_clk_i);
		if (k == 2000) begin
			err_count++;
			$display("[FAIL] %0t: no frame start", $time);
			end_sim();
		end
	endtask

	always @(negedge core_clk_i) begin
		if (ch1 === 1'b1) w1++;
		else if (w1 > 0) begin
			cmp_width(w1, q1);
			w1 = 0;
		end
		if (ch2 === 1'b1) w2++;
		else if (w2 > 0) begin
			cmp_width(w2, q2);
			w2 = 0;
		end
		if (latch === 1'b1) cmp_code({dig_b_rx, dig_a_rx}, qc);
		if (frame_start === 1'b1) cmp_start({prev_car, carrier_on});
		prev_car = carrier_on;
	end

	initial begin
		// the marker sent after reset closes an empty count
		qc.push_back(2'h0);
		set_frame(0);
		repeat (8) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		for (int i = 1; i < 13; i++) begin
			wait_start();
			set_frame(i);
		end
		for (int k = 0; k < 3000 && q1.size() + q2.size() + qc.size() > 0; k++) @(negedge core_clk_i);
		if (q1.size() + q2.size() + qc.size() > 0) begin
			err_count++;
			$display("[FAIL] %0t: results missing", $time);
		end
		end_sim();
	end
endmodule
